/* File: logic/homing_method_sequencer.sv */
`include "homing_consts.svh"

module homing_method_sequencer
  import homing_pkg::*;
#(
  parameter int SPD_W = 16
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic homing_start,
  input wire logic [`HM_METHOD_W-1:0] homing_method,
  input wire logic [SPD_W-1:0] high_speed,
  input wire logic [SPD_W-1:0] low_speed,
  input wire switch_in_s switches,
  output logic [SPD_W-1:0] speed_cmd,
  output logic dir_fwd,
  output logic busy,
  output logic homing_done,
  output logic method_error
);
  typedef struct packed {
    seq_state_e st;
    logic [`HM_METHOD_W-1:0] method;
    logic start_hi;
    logic [`HM_STEP_W-1:0] step;
    logic flip;
    logic [SPD_W-1:0] speed;
    logic fwd;
    logic busy;
    logic done;
    logic bad;
  } seq_s;

  seq_s s_q;
  seq_s s_d;
  logic rst_meta_q;
  logic rst_sync_n;
  switch_in_s ed_lvl;
  switch_in_s ed_rise;
  switch_in_s ed_fall;
  step_s cur;
  step_s nxt;
  logic hit;
  logic limit_hit;
  logic start_ok;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  switch_edge_detect u_edges (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n),
    .sw_in(switches),
    .lvl(ed_lvl),
    .rise(ed_rise),
    .fall(ed_fall)
  );

  // ----------------------------------------------------------------
  // Method programs
  // ----------------------------------------------------------------
  function automatic step_s mk(input logic last, input logic fast,
                               input logic fwd, input ev_e ev);
    mk = '{last: last, fast: fast, fwd: fwd, ev: ev};
  endfunction

  function automatic logic valid_method(input logic [`HM_METHOD_W-1:0] m);
    valid_method = (m >= `HM_METHOD_12 && m <= `HM_METHOD_14) ||
                   (m >= `HM_METHOD_17 && m <= `HM_METHOD_23);
  endfunction

  // Each step: last, fast, forward, event that ends it
  function automatic step_s plan(input logic [`HM_METHOD_W-1:0] m,
                                 input logic hi,
                                 input logic [`HM_STEP_W-1:0] k);
    plan = mk(1'b1, 1'b0, 1'b0, ev_index);
    case (m)
      `HM_METHOD_12:
        if (!hi)
          case (k)
            2'h0: plan = mk(1'b0, 1'b1, 1'b0, ev_home_rise);
            2'h1: plan = mk(1'b0, 1'b0, 1'b1, ev_home_fall);
            2'h2: plan = mk(1'b0, 1'b0, 1'b0, ev_home_rise);
            default: plan = mk(1'b1, 1'b0, 1'b0, ev_index);
          endcase
        else
          case (k)
            2'h0: plan = mk(1'b0, 1'b0, 1'b1, ev_home_fall);
            2'h1: plan = mk(1'b0, 1'b0, 1'b0, ev_home_rise);
            default: plan = mk(1'b1, 1'b0, 1'b0, ev_index);
          endcase
      `HM_METHOD_13:
        if (!hi)
          case (k)
            2'h0: plan = mk(1'b0, 1'b1, 1'b0, ev_home_rise);
            2'h1: plan = mk(1'b0, 1'b0, 1'b0, ev_home_fall);
            2'h2: plan = mk(1'b0, 1'b0, 1'b1, ev_home_rise);
            default: plan = mk(1'b1, 1'b0, 1'b1, ev_index);
          endcase
        else
          case (k)
            2'h0: plan = mk(1'b0, 1'b0, 1'b0, ev_home_fall);
            2'h1: plan = mk(1'b0, 1'b0, 1'b1, ev_home_rise);
            default: plan = mk(1'b1, 1'b0, 1'b1, ev_index);
          endcase
      `HM_METHOD_14:
        if (!hi)
          case (k)
            2'h0: plan = mk(1'b0, 1'b1, 1'b0, ev_home_rise);
            2'h1: plan = mk(1'b0, 1'b0, 1'b0, ev_home_fall);
            default: plan = mk(1'b1, 1'b0, 1'b0, ev_index);
          endcase
        else if (k == `HM_STEP_FIRST)
          plan = mk(1'b0, 1'b0, 1'b0, ev_home_fall);
        else
          plan = mk(1'b1, 1'b0, 1'b0, ev_index);
      `HM_METHOD_17:
        if (!hi && k == `HM_STEP_FIRST)
          plan = mk(1'b0, 1'b1, 1'b0, ev_rev_rise);
        else
          plan = mk(1'b1, 1'b0, 1'b1, ev_rev_fall);
      `HM_METHOD_18:
        if (!hi && k == `HM_STEP_FIRST)
          plan = mk(1'b0, 1'b1, 1'b1, ev_fwd_rise);
        else
          plan = mk(1'b1, 1'b0, 1'b0, ev_fwd_fall);
      `HM_METHOD_19:
        if (!hi && k == `HM_STEP_FIRST)
          plan = mk(1'b0, 1'b1, 1'b1, ev_home_rise);
        else
          plan = mk(1'b1, 1'b0, 1'b0, ev_home_fall);
      `HM_METHOD_20:
        if (hi && k == `HM_STEP_FIRST)
          plan = mk(1'b0, 1'b1, 1'b0, ev_home_fall);
        else
          plan = mk(1'b1, 1'b0, 1'b1, ev_home_rise);
      `HM_METHOD_21:
        if (!hi && k == `HM_STEP_FIRST)
          plan = mk(1'b0, 1'b1, 1'b0, ev_home_rise);
        else
          plan = mk(1'b1, 1'b0, 1'b1, ev_home_fall);
      `HM_METHOD_22:
        if (hi && k == `HM_STEP_FIRST)
          plan = mk(1'b0, 1'b1, 1'b1, ev_home_fall);
        else
          plan = mk(1'b1, 1'b0, 1'b0, ev_home_rise);
      `HM_METHOD_23:
        if (!hi && k == `HM_STEP_FIRST)
          plan = mk(1'b0, 1'b1, 1'b1, ev_home_rise);
        else
          plan = mk(1'b1, 1'b0, 1'b0, ev_home_fall);
      default: plan = mk(1'b1, 1'b0, 1'b0, ev_index);
    endcase
  endfunction

  // Index counts on its rising edge so a wide pulse counts once
  function automatic logic ev_hit(input ev_e ev, input switch_in_s r,
                                  input switch_in_s f);
    unique case (ev)
      ev_home_rise: ev_hit = r.home_switch;
      ev_home_fall: ev_hit = f.home_switch;
      ev_rev_rise: ev_hit = r.reverse_overtravel_switch;
      ev_rev_fall: ev_hit = f.reverse_overtravel_switch;
      ev_fwd_rise: ev_hit = r.forward_overtravel_switch;
      ev_fwd_fall: ev_hit = f.forward_overtravel_switch;
      ev_index: ev_hit = r.encoder_index;
      default: ev_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    cur = plan(s_q.method, s_q.start_hi, s_q.step);
    hit = ev_hit(cur.ev, ed_rise, ed_fall);
    // Limit only turns the first fast run round, and only once
    limit_hit = s_q.step == `HM_STEP_FIRST && cur.fast && !s_q.flip &&
                (((s_q.method >= `HM_METHOD_12) &&
                  (s_q.method <= `HM_METHOD_14) && !s_q.fwd &&
                  ed_lvl.reverse_overtravel_switch) ||
                 ((s_q.method == `HM_METHOD_23) && s_q.fwd &&
                  ed_lvl.forward_overtravel_switch));
    start_ok = homing_start && s_q.st != st_run &&
               valid_method(homing_method);
    unique case (s_q.st)
      st_idle, st_done:
        if (homing_start)
        begin
          s_d.bad = !start_ok;
          if (start_ok)
          begin
            s_d.st = st_run;
            s_d.method = homing_method;
            s_d.start_hi =
              (homing_method == `HM_METHOD_17) ?
                ed_lvl.reverse_overtravel_switch :
              (homing_method == `HM_METHOD_18) ?
                ed_lvl.forward_overtravel_switch : ed_lvl.home_switch;
            s_d.step = `HM_STEP_FIRST;
            s_d.flip = 1'b0;
            s_d.done = 1'b0;
            s_d.busy = 1'b1;
          end
        end
      st_run:
        if (limit_hit)
          s_d.flip = 1'b1;
        else if (hit)
        begin
          if (cur.last)
          begin
            s_d.st = st_done;
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
          end
          else
            s_d.step = s_q.step + `HM_STEP_INC;
        end
    endcase
    nxt = plan(s_d.method, s_d.start_hi, s_d.step);
    if (s_d.st == st_run)
    begin
      s_d.speed = nxt.fast ? high_speed : low_speed;
      s_d.fwd = nxt.fwd ^ (s_d.flip && s_d.step == `HM_STEP_FIRST);
    end
    else
      s_d.speed = '0;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign speed_cmd = s_q.speed;
  assign dir_fwd = s_q.fwd;
  assign busy = s_q.busy;
  assign homing_done = s_q.done;
  assign method_error = s_q.bad;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_sync_n);

  done_hold_a: assert property (
    homing_done && !homing_start |=> homing_done && speed_cmd == '0)
    else $error("done state left or speed not zero");
  m12_hi_start_a: assert property (
    start_ok && homing_method == `HM_METHOD_12 && ed_lvl.home_switch
    |=> dir_fwd && speed_cmd == $past(low_speed) && busy)
    else $error("method 12 high start not slow forward");
  m13_hi_start_a: assert property (
    start_ok && homing_method == `HM_METHOD_13 && ed_lvl.home_switch
    |=> !dir_fwd && speed_cmd == $past(low_speed))
    else $error("method 13 high start not slow reverse");
  m19_lo_start_a: assert property (
    start_ok && homing_method == `HM_METHOD_19 && !ed_lvl.home_switch
    |=> dir_fwd && speed_cmd == $past(high_speed))
    else $error("method 19 low start not fast forward");
  m20_lo_start_a: assert property (
    start_ok && homing_method == `HM_METHOD_20 && !ed_lvl.home_switch
    |=> dir_fwd && speed_cmd == $past(low_speed))
    else $error("method 20 low start not slow forward");
  m22_hi_start_a: assert property (
    start_ok && homing_method == `HM_METHOD_22 && ed_lvl.home_switch
    |=> dir_fwd && speed_cmd == $past(high_speed))
    else $error("method 22 high start not fast forward");
  m18_hi_start_a: assert property (
    start_ok && homing_method == `HM_METHOD_18 &&
    ed_lvl.forward_overtravel_switch
    |=> !dir_fwd && speed_cmd == $past(low_speed))
    else $error("method 18 high start not slow reverse");
  rev_limit_turn_a: assert property (
    busy && limit_hit && !dir_fwd |=> dir_fwd && s_q.step == '0)
    else $error("reverse limit did not turn fast run");
  fwd_limit_turn_a: assert property (
    busy && limit_hit && s_q.method == `HM_METHOD_23 && dir_fwd
    |=> !dir_fwd && s_q.flip)
    else $error("forward limit did not turn method 23");
  m17_stop_a: assert property (
    busy && s_q.method == `HM_METHOD_17 && cur.last &&
    ed_fall.reverse_overtravel_switch
    |=> homing_done && !busy && speed_cmd == '0)
    else $error("method 17 did not stop on limit fall");
  index_stop_a: assert property (
    busy && s_q.method == `HM_METHOD_14 && cur.last &&
    ed_rise.encoder_index && !limit_hit |=> homing_done ##1 homing_done)
    else $error("method 14 did not stop on index");

  start_done_c: cover property (start_ok ##[1:400] homing_done);
  limit_turn_c: cover property (busy && limit_hit ##[1:400] homing_done);
  bad_method_c: cover property (homing_start ##1 method_error);
endmodule // homing_method_sequencer

/* File: include/homing_consts.svh */
// Operation
// - M12 home low: fast rev, slow fwd, slow rev, index after home rise.
// - M12 reverse limit in fast rev: fast fwd, then as from home rise.
// - M12 home high: slow fwd, fall reverses, index after home rise.
// - M13 home low: fast rev, slow rev, fall to slow fwd, index after rise.
// - M13 reverse limit: fast fwd, rise to slow rev, fall to slow fwd, index.
// - M13 home high: slow rev, fall reverses, index after rise in slow fwd.
// - M14 home low: fast rev, slow rev past fall, stop at first index.
// - M14 reverse limit: fast fwd, rise to slow rev, index after fall.
// - M14 home high: slow rev, stop at first index after home fall.
// - M17 reverse limit low: fast rev, reverse-limit rise to slow fwd, stop on its fall.
// - M18 forward limit low: fast fwd, rise to slow rev, stop on fall.
// - M18 forward limit high: slow rev, stop on its falling edge.
// - M19 home low: fast fwd, rise to slow rev, stop on home fall.
// - M19 home high: slow rev, stop on home fall.
// - M20 home low: slow fwd, stop on home rise.
// - M20 home high: fast rev, fall to slow fwd, stop on home rise.
// - M21 home low: fast rev, rise to slow fwd, stop on home fall.
// - M21 home high: slow fwd, stop on home fall.
// - M22 home low: slow rev, stop on home rise.
// - M22 home high: fast fwd, fall to slow rev, stop on home rise.
// - M23 home low: fast fwd, rise to slow rev, stop on home fall.
// - M23 forward limit in fast fwd: fast rev, rise slows, stop on fall.
`ifndef HOMING_CONSTS_SVH
`define HOMING_CONSTS_SVH
`define HM_METHOD_W 8
`define HM_METHOD_12 8'h0C
`define HM_METHOD_13 8'h0D
`define HM_METHOD_14 8'h0E
`define HM_METHOD_17 8'h11
`define HM_METHOD_18 8'h12
`define HM_METHOD_19 8'h13
`define HM_METHOD_20 8'h14
`define HM_METHOD_21 8'h15
`define HM_METHOD_22 8'h16
`define HM_METHOD_23 8'h17
`define HM_STEP_W 2
`define HM_STEP_FIRST 2'h0
`define HM_STEP_INC 2'h1
`endif

/* File: include/homing_pkg.sv */
package homing_pkg;
  typedef enum logic [2:0] {
    ev_home_rise,
    ev_home_fall,
    ev_rev_rise,
    ev_rev_fall,
    ev_fwd_rise,
    ev_fwd_fall,
    ev_index
  } ev_e;
  typedef enum logic [1:0] {st_idle, st_run, st_done} seq_state_e;
  typedef struct packed {
    logic last;
    logic fast;
    logic fwd;
    ev_e ev;
  } step_s;
  typedef struct packed {
    logic home_switch;
    logic forward_overtravel_switch;
    logic reverse_overtravel_switch;
    logic encoder_index;
  } switch_in_s;
endpackage

/* File: logic/switch_edge_detect.sv */
module switch_edge_detect
  import homing_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_sync_n,
  input wire switch_in_s sw_in,
  output switch_in_s lvl,
  output switch_in_s rise,
  output switch_in_s fall
);
  typedef struct packed {
    switch_in_s cur;
    switch_in_s prev;
  } edge_state_s;

  edge_state_s s_q;
  edge_state_s s_d;

  always_comb
  begin
    s_d.cur = sw_in;
    s_d.prev = s_q.cur;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign lvl = s_q.cur;
  assign rise = switch_in_s'(s_q.cur & ~s_q.prev);
  assign fall = switch_in_s'(~s_q.cur & s_q.prev);
endmodule // switch_edge_detect

/* File: test/switch_axis_model.sv */
module switch_axis_model
  import homing_pkg::*;
#(
  parameter int SPD_W = 16
)
(
  input wire logic core_clk,
  input wire logic busy,
  input wire logic dir_fwd,
  input wire logic [SPD_W-1:0] speed_cmd,
  input wire logic load,
  input var int load_pos,
  output switch_in_s switches
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Axis position and switch map
  // ----------------------------------------
  // Index marks sit outside the home window, so no index edge coincides
  // with a home edge
  localparam int HOME_LO = 205;
  localparam int HOME_HI = 265;
  localparam int REV_END = 20;
  localparam int FWD_END = 480;
  localparam int IDX_PITCH = 100;
  int pos_q = 0;

  always @(posedge core_clk)
  begin
    if (load)
      pos_q <= load_pos;
    else if (busy === 1'b1)
      pos_q <= dir_fwd ? pos_q + int'(speed_cmd) : pos_q - int'(speed_cmd);
  end

  always_comb
  begin
    switches.home_switch = (pos_q >= HOME_LO) && (pos_q <= HOME_HI);
    switches.forward_overtravel_switch = pos_q >= FWD_END;
    switches.reverse_overtravel_switch = pos_q <= REV_END;
    switches.encoder_index = (pos_q % IDX_PITCH) == 0;
  end
endmodule // switch_axis_model

/* File: test/tb_top.sv */
`include "homing_consts.svh"

module tb_top
  import homing_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst_n, homing_start, load;
  logic [`HM_METHOD_W-1:0] homing_method;
  logic [15:0] high_speed, low_speed, speed_cmd;
  logic dir_fwd, busy, homing_done, method_error;
  switch_in_s switches;
  int load_pos, err_total, comparisons;

  homing_method_sequencer #(.SPD_W(16)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .homing_start(homing_start),
    .homing_method(homing_method), .high_speed(high_speed),
    .low_speed(low_speed), .switches(switches), .speed_cmd(speed_cmd),
    .dir_fwd(dir_fwd), .busy(busy), .homing_done(homing_done),
    .method_error(method_error));

  switch_axis_model #(.SPD_W(16)) u_axis (
    .core_clk(core_clk), .busy(busy), .dir_fwd(dir_fwd),
    .speed_cmd(speed_cmd), .load(load), .load_pos(load_pos),
    .switches(switches));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task stop_test;
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task tick;
    @(posedge core_clk);
    #2;
  endtask

  // Segment code {dir_fwd, fast}, expected codes one per nibble, first
  // segment in the most significant used nibble
  task automatic run(input logic [7:0] m, input int p, input int n,
                     input logic [15:0] exp);
    logic [1:0] seg[$];
    logic [1:0] code;
    int i;
    load = 1'b1;
    load_pos = p;
    tick;
    load = 1'b0;
    repeat (3) tick;
    homing_method = m;
    homing_start = 1'b1;
    tick;
    homing_start = 1'b0;
    i = 0;
    while (homing_done !== 1'b1 && i < 4000)
    begin
      code = {dir_fwd, speed_cmd === high_speed};
      if (busy === 1'b1 && (seg.size() == 0 || seg[$] !== code))
        seg.push_back(code);
      if (busy === 1'b1 && speed_cmd !== high_speed)
        check(speed_cmd, low_speed);
      tick;
      i++;
    end
    if (i >= 4000)
    begin
      err_total++;
      stop_test;
    end
    check(seg.size(), n);
    for (i = 0; i < n && i < seg.size(); i++)
      check(seg[i], exp[4*(n-1-i) +: 2]);
    check({busy, speed_cmd}, 17'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_index_methods;
    run(`HM_METHOD_12, 300, 3, 16'h0120);
    run(`HM_METHOD_12, 100, 4, 16'h1320);
    run(`HM_METHOD_12, 230, 2, 16'h0020);
    run(`HM_METHOD_13, 300, 3, 16'h0102);
    run(`HM_METHOD_13, 100, 4, 16'h1302);
    run(`HM_METHOD_13, 230, 2, 16'h0002);
    run(`HM_METHOD_14, 300, 2, 16'h0010);
    run(`HM_METHOD_14, 100, 3, 16'h0130);
    run(`HM_METHOD_14, 230, 1, 16'h0000);
  endtask

  task t_limit_methods;
    run(`HM_METHOD_17, 100, 2, 16'h0012);
    run(`HM_METHOD_18, 300, 2, 16'h0030);
    run(`HM_METHOD_18, 490, 1, 16'h0000);
  endtask

  task t_home_methods;
    run(`HM_METHOD_19, 100, 2, 16'h0030);
    run(`HM_METHOD_19, 230, 1, 16'h0000);
    run(`HM_METHOD_20, 100, 1, 16'h0002);
    run(`HM_METHOD_20, 230, 2, 16'h0012);
    run(`HM_METHOD_21, 300, 2, 16'h0012);
    run(`HM_METHOD_21, 230, 1, 16'h0002);
    run(`HM_METHOD_22, 300, 1, 16'h0000);
    run(`HM_METHOD_22, 230, 2, 16'h0030);
    run(`HM_METHOD_23, 100, 2, 16'h0030);
    run(`HM_METHOD_23, 300, 3, 16'h0310);
  endtask

  // Done must persist at zero speed; a refused code leaves it standing
  task t_done_and_refusal;
    logic [7:0] bad [4];
    int k;
    bad = '{8'h0B, 8'h0F, 8'h10, 8'h18};
    repeat (20) tick;
    check({homing_done, busy, speed_cmd}, {1'b1, 17'h0});
    for (k = 0; k < 4; k++)
    begin
      homing_method = bad[k];
      homing_start = 1'b1;
      tick;
      homing_start = 1'b0;
      tick;
      check({method_error, homing_done, busy}, 3'b110);
    end
    run(`HM_METHOD_20, 100, 1, 16'h0002);
    check(method_error, 1'b0);
  endtask

  // ----------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial
  begin
    rst_n = 1'b0;
    homing_start = 1'b0;
    homing_method = `HM_METHOD_12;
    high_speed = 16'h0004;
    low_speed = 16'h0001;
    load = 1'b0;
    load_pos = 100;
    err_total = 0;
    comparisons = 0;
    repeat (5) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    repeat (4) tick;
    check({busy, homing_done, method_error, speed_cmd}, 19'h0);
    t_index_methods;
    t_limit_methods;
    t_home_methods;
    t_done_and_refusal;
    stop_test;
  end
endmodule // tb_top
